// ===== src/sssrw_consts.svh
// Purpose: Constants for the SPI status response word block.
// Assumes: Included by bare name from every file that needs a constant.
// Notes: Flag indices 7..0 match the detailed status bit positions 7..0.
`ifndef SSSRW_CONSTS_SVH
`define SSSRW_CONSTS_SVH

// Frame geometry, counted in SPI bits.
`define SSSRW_WORD_BITS 5'h10
`define SSSRW_BYTE_BITS 5'h08
`define SSSRW_CNT_W 5

// Command-type code that marks a write; every other code is a read.
`define SSSRW_CMD_WRITE 2'h1

// Pending flag indices inside the flag vector.
`define SSSRW_NFLAGS 12
`define SSSRW_FLG_INT 11
`define SSSRW_FLG_WAKE 10
`define SSSRW_FLG_RST 9
`define SSSRW_FLG_SAFE 8
`define SSSRW_FLG_CAN_BUS 7
`define SSSRW_FLG_CAN_LOC 6
`define SSSRW_FLG_LIN_CHANNEL_TWO_SOURCE 5
`define SSSRW_FLG_LIN_CHANNEL_ONE_SOURCE 4
`define SSSRW_FLG_IO_HI 3
`define SSSRW_FLG_IO_LO 2
`define SSSRW_FLG_REG_HI 1
`define SSSRW_FLG_REG_LO 0

// Positions of the summary and group bits in the status word.
`define SSSRW_SW_INT 15
`define SSSRW_SW_WAKE 14
`define SSSRW_SW_RST 13
`define SSSRW_SW_CAN_G 12

// Reset values.
`define SSSRW_FLAGS_RST 12'h000
`define SSSRW_WORD_RST 16'h0000

`endif

// ===== src/sssrw_pkg.sv
// Purpose: Types shared by the status response word block.
// Assumes: Nothing beyond the constants header.
// Notes: State codes are one-hot.
`default_nettype none
package sssrw_pkg;
  typedef logic [15:0] sssrw_word_type;
  typedef logic [7:0] sssrw_byte_type;
  typedef logic [11:0] sssrw_flags_type;
  typedef enum logic [1:0] {
    SSSRW_ST_IDLE = 2'h1,
    SSSRW_ST_XFER = 2'h2
  } sssrw_state_type;
endpackage
`default_nettype wire

// ===== src/sssrw_flag_if.sv
// Purpose: Carries event flags between the core and its flag bank.
// Assumes: All signals live in the clk_sys domain.
// Notes: The bank drives pending; the core drives the rest.
`default_nettype none
interface sssrw_flag_if #(parameter int N = 12);
  logic [N-1:0] set;
  logic [N-1:0] clr;
  logic [N-1:0] level;
  logic [N-1:0] pending;
  modport bank (input set, input clr, input level, output pending);
  modport user (output set, output clr, output level, input pending);
endinterface
`default_nettype wire

// ===== src/sssrw_flag_bank.sv
// Purpose: Sticky event flags cleared by a flag read, plus real-time levels.
// Assumes: set, clr and level come from logic on clk_sys.
// Notes: A set in the same cycle as a clear wins, so no event is lost.
`include "sssrw_consts.svh"
`default_nettype none
module sssrw_flag_bank #(
  parameter int N = 12
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  sssrw_flag_if.bank fl
);
  import sssrw_pkg::*;

  logic [N-1:0] sticky_r;
  logic [N-1:0] sticky_nxt;

  // Latched events fall only on a read; set has priority over clear.
  assign sticky_nxt = fl.set | (sticky_r & ~fl.clr);
  // Real-time levels bypass the latch, so a read can never clear them.
  assign fl.pending = sticky_r | fl.level;

  // Flag storage.
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      sticky_r <= '0;
    end else begin
      sticky_r <= sticky_nxt;
    end
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  // A latched bit drops only in the cycle after a read of it.
  a_sticky_only_read:
    assert property (1'b1 |=> ((~sticky_r & $past(sticky_r) & ~$past(fl.clr)) == '0))
    else $error("Latched flag dropped without a read.");
  // An event is held even when a read clears in the same cycle.
  a_set_wins_clear:
    assert property ((fl.set != '0) |=> ((sticky_r & $past(fl.set)) == $past(fl.set)))
    else $error("Event lost against a simultaneous read.");
  // A steady real-time level stays pending across a read.
  a_realtime_kept:
    assert property ((fl.clr & fl.level) != '0 |=>
      ((fl.pending & $past(fl.level) & fl.level) == ($past(fl.level) & fl.level)))
    else $error("Real-time flag cleared by a read.");
endmodule
`default_nettype wire

// ===== src/sssrw_core.sv
// Purpose: Builds and shifts out the status word returned for each SPI command.
// Assumes: SPI mode 0 frames of 16 bits; sclk, cs_n and mosi are asynchronous pins.
// Notes: sclk must stay well below clk_sys/4 since its edges are found by sampling.
//
// Behaviour
// - Write command returns fixed and extended status.
// - Read command returns fixed status byte only.
// - Bit 15 shows pending unread interrupt flags.
// - Bit 14 shows pending unread wake-up flags.
// - Bit 13 shows pending unread reset-cause flags.
// - CAN local source bit, reflected in group.
// - CAN bus source bit set from bus.
// - Second LIN channel source bit.
// - First LIN channel source bit.
// - I/O low sub-address source bit.
// - I/O high sub-address source bit.
// - Regulator high sub-address source bit.
// - Regulator low sub-address source bit.
// - Latched flags clear only on SPI read.
// - Real-time flags never cleared by reads.
`include "sssrw_consts.svh"
`default_nettype none
module sssrw_core (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic mosi,
  input wire sssrw_pkg::sssrw_flags_type event_set,
  input wire sssrw_pkg::sssrw_flags_type flag_read_clear,
  input wire sssrw_pkg::sssrw_flags_type realtime_level,
  input wire sssrw_pkg::sssrw_byte_type reg_read_data,
  output logic miso,
  output logic miso_oe,
  output sssrw_pkg::sssrw_word_type cmd_word,
  output logic cmd_done,
  output logic cmd_is_write
);
  import sssrw_pkg::*;

  logic [2:0] sync1_r;
  logic [2:0] sync2_r;
  logic sclk_q_r;
  sssrw_state_type state_r;
  sssrw_state_type state_nxt;
  sssrw_word_type tx_r;
  sssrw_word_type tx_nxt;
  sssrw_word_type rx_r;
  sssrw_word_type rx_nxt;
  logic [`SSSRW_CNT_W-1:0] cnt_r;
  logic [`SSSRW_CNT_W-1:0] cnt_nxt;
  logic miso_oe_r;
  logic cmd_done_r;
  logic cmd_is_write_r;
  sssrw_word_type cmd_word_r;
  sssrw_byte_type ext_snap_r;

  sssrw_flag_if #(.N(`SSSRW_NFLAGS)) fl ();

  sssrw_flag_bank #(.N(`SSSRW_NFLAGS)) u_flags (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .fl(fl)
  );

  // Flag bank feeds; the outer flag-read decoder supplies the clear strobes.
  assign fl.set = event_set;
  assign fl.clr = flag_read_clear;
  assign fl.level = realtime_level;

  // Two-stage synchronisers for the three SPI pins, then edge detection.
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      sync1_r <= 3'h2;
      sync2_r <= 3'h2;
      sclk_q_r <= 1'b0;
    end else begin
      sync1_r <= {sclk, cs_n, mosi};
      sync2_r <= sync1_r;
      sclk_q_r <= sync2_r[2];
    end
  end

  wire sclk_s = sync2_r[2];
  wire cs_act = ~sync2_r[1];
  wire mosi_s = sync2_r[0];
  wire sclk_rise = sclk_s & ~sclk_q_r;
  wire sclk_fall = ~sclk_s & sclk_q_r;

  // Group bits are the OR of their currently pending detailed sources.
  wire [`SSSRW_NFLAGS-1:0] p = fl.pending;
  wire can_g = p[`SSSRW_FLG_CAN_LOC] | p[`SSSRW_FLG_CAN_BUS];
  wire lin_g = p[`SSSRW_FLG_LIN_CHANNEL_TWO_SOURCE] | p[`SSSRW_FLG_LIN_CHANNEL_ONE_SOURCE];
  wire io_g = p[`SSSRW_FLG_IO_HI] | p[`SSSRW_FLG_IO_LO];
  wire safe_g = p[`SSSRW_FLG_SAFE];
  wire reg_g = p[`SSSRW_FLG_REG_HI] | p[`SSSRW_FLG_REG_LO];

  // Fixed byte: summary and group bits.
  wire [7:0] fixed_byte = {p[`SSSRW_FLG_INT],
                           p[`SSSRW_FLG_WAKE],
                           p[`SSSRW_FLG_RST],
                           can_g, lin_g, io_g, safe_g, reg_g};
  // Extended byte: one bit per detailed source.
  wire [7:0] ext_byte = {p[`SSSRW_FLG_CAN_BUS],
                         p[`SSSRW_FLG_CAN_LOC],
                         p[`SSSRW_FLG_LIN_CHANNEL_TWO_SOURCE],
                         p[`SSSRW_FLG_LIN_CHANNEL_ONE_SOURCE],
                         p[`SSSRW_FLG_IO_HI],
                         p[`SSSRW_FLG_IO_LO],
                         p[`SSSRW_FLG_REG_HI],
                         p[`SSSRW_FLG_REG_LO]};
  wire [15:0] status_word = {fixed_byte, ext_byte};

  // Frame sequencing decodes.
  wire in_xfer = (state_r == SSSRW_ST_XFER);
  wire frame_start = (state_r == SSSRW_ST_IDLE) & cs_act;
  wire frame_end = in_xfer & ~cs_act;
  wire cnt_full = (cnt_r == `SSSRW_WORD_BITS);
  wire bit_in = in_xfer & sclk_rise & ~cnt_full;
  wire bit_out = in_xfer & sclk_fall & (cnt_r != '0);
  // The command type is the first two bits, known well before the byte boundary.
  wire is_write = (rx_r[7:6] == `SSSRW_CMD_WRITE);
  wire byte_swap = bit_out & (cnt_r == `SSSRW_BYTE_BITS);
  wire read_swap = byte_swap & ~is_write;

  assign state_nxt = frame_start ? SSSRW_ST_XFER :
                     frame_end ? SSSRW_ST_IDLE : state_r;
  // The word is snapshotted at chip select so both bytes are coherent.
  // A write just keeps shifting into the extended byte; a read swaps it out.
  assign tx_nxt = frame_start ? status_word :
                  read_swap ? {reg_read_data, 8'h00} :
                  bit_out ? {tx_r[14:0], 1'b0} : tx_r;
  assign rx_nxt = frame_start ? `SSSRW_WORD_RST :
                  bit_in ? {rx_r[14:0], mosi_s} : rx_r;
  assign cnt_nxt = frame_start ? '0 :
                   bit_in ? cnt_r + `SSSRW_CNT_W'(1) : cnt_r;

  // Shift engine; words shorter than 16 bits are not reported, longer ones report their first 16 bits.
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= SSSRW_ST_IDLE;
      tx_r <= `SSSRW_WORD_RST;
      rx_r <= `SSSRW_WORD_RST;
      cnt_r <= '0;
      miso_oe_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      tx_r <= tx_nxt;
      rx_r <= rx_nxt;
      cnt_r <= cnt_nxt;
      miso_oe_r <= (state_nxt == SSSRW_ST_XFER);
    end
  end

  // Received command hand-off, plus the extended byte kept for checking.
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      cmd_done_r <= 1'b0;
      cmd_is_write_r <= 1'b0;
      cmd_word_r <= `SSSRW_WORD_RST;
      ext_snap_r <= 8'h00;
    end else begin
      cmd_done_r <= frame_end & cnt_full;
      if (frame_end & cnt_full) begin
        cmd_word_r <= rx_r;
        cmd_is_write_r <= (rx_r[15:14] == `SSSRW_CMD_WRITE);
      end
      if (frame_start) begin
        ext_snap_r <= ext_byte;
      end
    end
  end

  assign miso = tx_r[15];
  assign miso_oe = miso_oe_r;
  assign cmd_word = cmd_word_r;
  assign cmd_done = cmd_done_r;
  assign cmd_is_write = cmd_is_write_r;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  a_write_ext_byte:
    assert property (byte_swap & is_write |=> tx_r[15:8] == ext_snap_r)
    else $error("Write did not return the extended status byte.");
  a_read_one_byte:
    assert property (byte_swap & ~is_write |=> tx_r[15:8] == $past(reg_read_data))
    else $error("Read returned status beyond the fixed byte.");
  a_int_summary:
    assert property (frame_start |=> tx_r[`SSSRW_SW_INT] == $past(p[`SSSRW_FLG_INT]))
    else $error("Interrupt summary bit wrong at frame start.");
  a_wake_summary:
    assert property (frame_start |=> tx_r[`SSSRW_SW_WAKE] == $past(p[`SSSRW_FLG_WAKE]))
    else $error("Wake-up summary bit wrong at frame start.");
  a_reset_summary:
    assert property (frame_start |=> tx_r[`SSSRW_SW_RST] == $past(p[`SSSRW_FLG_RST]))
    else $error("Reset summary bit wrong at frame start.");
  a_can_group_bit:
    assert property (frame_start & p[`SSSRW_FLG_CAN_LOC] |=> tx_r[`SSSRW_SW_CAN_G])
    else $error("CAN group bit missed a pending local source.");
  a_group_or:
    assert property (frame_start |=> tx_r[11:8] ==
      $past({p[5] | p[4], p[3] | p[2], p[8], p[1] | p[0]}))
    else $error("Group bits are not the OR of their sources.");
  a_detail_bits:
    assert property (frame_start |=> tx_r[7:0] == $past(p[7:0]))
    else $error("Detailed source bits misplaced.");
  a_msb_first_shift:
    assert property (bit_out & (cnt_r != `SSSRW_BYTE_BITS) |=> tx_r[15] == $past(tx_r[14]))
    else $error("MISO did not advance one bit, MSB first.");
  a_drive_in_frame:
    assert property (cs_act & in_xfer |=> miso_oe ##1 (miso_oe || !$past(cs_act)))
    else $error("MISO not driven while chip select is active.");

  c_write_frame: cover property (cmd_done & cmd_is_write);
  c_read_frame: cover property (cmd_done & ~cmd_is_write);
  c_int_reported: cover property (frame_start & p[`SSSRW_FLG_INT]);
  c_set_on_clear: cover property ((event_set & flag_read_clear) != '0);
endmodule
`default_nettype wire

// ===== tb/sssrw_spi_master.sv
// Purpose: SPI master model that sends one command frame at a time.
// Assumes: Mode 0 with a 320 ns link clock made from 8 clk_sys periods.
// Notes: Sclk stands low outside frames; a released mosi shows its last bit inverted.
`default_nettype none
module sssrw_spi_master (
  input wire logic clk_sys,
  output logic sclk,
  output logic cs_n,
  output logic mosi,
  input wire logic miso
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] last_rx;
  initial begin
    sclk = 1'b0;
    cs_n = 1'b1;
    mosi = 1'b0;
    last_rx = 16'h0000;
  end
  // All pin changes land on falling clk_sys edges.
  task automatic hold(input int n);
    repeat (n) @(negedge clk_sys);
  endtask
  // Miso is taken late in the high phase, so the synchroniser delay never eats the margin.
  task automatic xfer(input logic [15:0] tx, input int nbits);
    logic [15:0] rx;
    rx = 16'h0000;
    cs_n = 1'b0;
    hold(8);
    for (int i = 0; i < nbits; i++) begin
      mosi = tx[15 - i];
      hold(4);
      sclk = 1'b1;
      hold(3);
      rx = {rx[14:0], miso};
      hold(1);
      sclk = 1'b0;
    end
    hold(4);
    last_rx = rx;
    cs_n = 1'b1;
    mosi = ~mosi;
    hold(8);
  endtask
endmodule
`default_nettype wire

// ===== tb/sssrw_core_tb.sv
// Purpose: Self-checking bench for the status response word block.
// Assumes: The master model drives the SPI pins; the bench drives the flag inputs.
// Notes: Expected words are queued per full 16-bit frame and checked when cmd_done pulses.
`default_nettype none
module sssrw_core_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import sssrw_pkg::*;
  typedef struct {sssrw_word_type cmd; logic wr; sssrw_word_type resp;} sssrw_note_type;
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  logic sclk, cs_n, mosi, miso, miso_oe, cmd_done, cmd_is_write;
  sssrw_flags_type event_set = 12'h000, flag_read_clear = 12'h000, realtime_level = 12'h000;
  sssrw_flags_type sticky_m = 12'h000;
  sssrw_byte_type reg_read_data = 8'h00;
  sssrw_word_type cmd_word;
  sssrw_note_type notes[$];
  sssrw_note_type note;
  int fails = 0, n_compared = 0, cycles = 0;
  always #20 clk_sys = ~clk_sys;
  sssrw_core sssrw_core_i (.clk_sys(clk_sys), .rst_n(rst_n), .sclk(sclk), .cs_n(cs_n),
    .mosi(mosi), .event_set(event_set), .flag_read_clear(flag_read_clear),
    .realtime_level(realtime_level), .reg_read_data(reg_read_data), .miso(miso),
    .miso_oe(miso_oe), .cmd_word(cmd_word), .cmd_done(cmd_done), .cmd_is_write(cmd_is_write));
  sssrw_spi_master sssrw_spi_master_i (.clk_sys(clk_sys), .sclk(sclk), .cs_n(cs_n),
    .mosi(mosi), .miso(miso));
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      fails++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic close_out();
    $display("Compared %0d, mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // Status word built from the pending flags.
  function automatic sssrw_word_type status_of(input sssrw_flags_type p);
    return {p[11], p[10], p[9],
      p[7] | p[6], p[5] | p[4], p[3] | p[2], p[8], p[1] | p[0],
      p[7:0]};
  endfunction
  // A set in the same cycle as a clear wins, so the model applies the clear first.
  task automatic pulse(input sssrw_flags_type s, input sssrw_flags_type c);
    @(negedge clk_sys);
    event_set = s;
    flag_read_clear = c;
    sticky_m = (sticky_m & ~c) | s;
    @(negedge clk_sys);
    event_set = 12'h000;
    flag_read_clear = 12'h000;
  endtask
  // Only a full frame is noted; a short one must give no cmd_done.
  task automatic frame(input sssrw_word_type cmd, input int nbits);
    sssrw_word_type r;
    r = status_of(sticky_m | realtime_level);
    if (cmd[15:14] != 2'h1) r[7:0] = reg_read_data;
    if (nbits == 16) notes.push_back('{cmd, cmd[15:14] == 2'h1, r});
    // Chip select is low for far longer than 12 cycles, so the drive is settled by then.
    fork
      sssrw_spi_master_i.xfer(cmd, nbits);
      begin
        repeat (12) @(negedge clk_sys);
        check("miso_oe in frame", 16'(miso_oe), 16'h0001);
      end
    join
  endtask
  // Results are taken off the queue as they appear.
  always @(negedge clk_sys) begin
    if (cmd_done === 1'b1) begin
      check("miso_oe after frame", 16'(miso_oe), 16'h0000);
      if (notes.size() == 0) check("unexpected cmd_done", 16'h0001, 16'h0000);
      else begin
        note = notes.pop_front();
        check("cmd_word", cmd_word, note.cmd);
        check("cmd_is_write", 16'(cmd_is_write), 16'(note.wr));
        check("miso_word", sssrw_spi_master_i.last_rx, note.resp);
      end
    end
  end
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 20000) begin
      fails++;
      close_out();
    end
  end
  initial begin
    void'($urandom(32'h2178ca57));
    repeat (4) @(negedge clk_sys);
    check("reset word", cmd_word, 16'h0000);
    check("reset oe", 16'(miso_oe), 16'h0000);
    rst_n = 1'b1;
    for (int c = 0; c < 4; c++) begin
      pulse(12'($urandom), 12'h000);
      reg_read_data = 8'($urandom);
      frame({2'(c), 14'($urandom)}, 16);
      pulse(12'h000, 12'hfff);
    end
    $display("Test command codes done");
    realtime_level = 12'($urandom);
    pulse(12'($urandom), 12'h000);
    pulse(12'h000, 12'hfff);
    frame(16'h4000, 16);
    frame(16'h2780, 16);
    realtime_level = 12'h000;
    $display("Test clearing done");
    pulse(12'h800, 12'hfff);
    frame(16'h4123, 16);
    $display("Test set over clear done");
    frame(16'h4000, 8);
    frame(16'h0000, 16);
    $display("Test short frame done");
    for (int k = 0; k < 6; k++) begin
      pulse(12'($urandom), 12'($urandom));
      reg_read_data = 8'($urandom);
      frame(16'($urandom), 16);
    end
    $display("Test random frames done");
    repeat (20) @(negedge clk_sys);
    if (notes.size() != 0) check("missing cmd_done", 16'(notes.size()), 16'h0000);
    close_out();
  end
endmodule
`default_nettype wire
